// >>> ubw_pkg.sv
// Package: register map, field positions, timing constants and state type of the serial port
package ubw_pkg;

  // Register byte offsets on the AHB-Lite bus
  localparam logic [7:0] OFF_PORT_CTRL  = 8'h00;
  localparam logic [7:0] OFF_RX_CTRL    = 8'h04;
  localparam logic [7:0] OFF_TX_HOLD    = 8'h08;
  localparam logic [7:0] OFF_RX_HOLD    = 8'h0C;
  localparam logic [7:0] OFF_PRESCALE   = 8'h10;
  localparam logic [7:0] OFF_DIVISOR    = 8'h14;
  localparam logic [7:0] OFF_WAKE_EN    = 8'h18;
  localparam logic [7:0] OFF_WAKE_EDGE  = 8'h1C;

  // Port control register fields
  localparam int PC_CHL_LO     = 0;
  localparam int PC_CHL_HI     = 1;
  localparam int PC_TX_NINTH   = 2;
  localparam int PC_TWO_STOP   = 3;
  localparam int PC_SHORT_STOP = 4;
  localparam int PC_SYNC       = 5;
  localparam int PC_TBE        = 6;
  localparam int PC_TX_BUSY    = 7;

  // Receive control and status register fields
  localparam int RC_RX_NINTH   = 0;
  localparam int RC_ADDR_WAIT  = 1;
  localparam int RC_FRAME_ERR  = 2;
  localparam int RC_OVERRUN    = 3;
  localparam int RC_RX_FULL    = 4;

  // Widths of the divider chain
  localparam int PSEL_W = 5;
  localparam int DIV_W  = 11;

  // Oversampling per bit: sixteen asynchronous, two synchronous
  localparam logic [4:0] OSR_ASYNC      = 5'h10;
  localparam logic [4:0] OSR_SYNC       = 5'h02;
  localparam logic [4:0] HALF_ASYNC     = 5'h08;
  localparam logic [4:0] HALF_SYNC      = 5'h01;
  localparam logic [4:0] STOP_SHORT_LEN = 5'h0E;

  // Wake source bit and oscillator settling delay in instruction cycles
  localparam int         WAKE_BIT    = 3;
  localparam int         HOLD_CYCLES = 256;
  localparam logic [8:0] HOLD_LOAD   = 9'(HOLD_CYCLES - 1);

  // Receiver states
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } ubw_rx_state_t;

  // Whole state of the port
  typedef struct packed {
    logic                wr_pend;
    logic [7:0]          wr_addr;
    logic [31:0]         hrdata;
    logic                chl_lo;
    logic                chl_hi;
    logic                tx9;
    logic                two_stop;
    logic                short_stop;
    logic                sync_mode;
    logic                addr_wait;
    logic [PSEL_W-1:0]   psel;
    logic [DIV_W-1:0]    div;
    logic [7:0]          wake_enable_reg;
    logic [7:0]          wake_edge_reg;
    logic                tbe;
    logic                rx_full;
    logic                rx9;
    logic                ferr;
    logic                oerr;
    logic [7:0]          tx_buf;
    logic [11:0]         tx_sh;
    logic [3:0]          tx_bits;
    logic [4:0]          tx_sub;
    logic                tx_active;
    ubw_rx_state_t       rx_st;
    logic [8:0]          rx_sh;
    logic [3:0]          rx_bits;
    logic [4:0]          rx_sub;
    logic [7:0]          rx_buf;
    logic [5:0]          pre_acc;
    logic [DIV_W-1:0]    div_cnt;
    logic                rx_s1;
    logic                rx_s2;
    logic                rx_prev;
    logic                lp;
    logic                lp_halt;
    logic                wake;
    logic                exec_hold;
    logic [8:0]          hold_cnt;
  } ubw_state_t;

endpackage : ubw_pkg

// >>> ubw_usart.sv
// Serial port with baud divider, low-power reinit and wake, loopback and address filtering
`timescale 1ns/1ps
module ubw_usart (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        serial_in_pin,
  output logic             serial_out_pin,
  input  wire logic        halt_enter,
  input  wire logic        idle_enter,
  input  wire logic        xtal_osc,
  output logic             wake_out,
  output logic             exec_hold
);

  ubw_pkg::ubw_state_t s_q;
  ubw_pkg::ubw_state_t s_d;

  // Frame shape decoded from the length bits
  logic             loopback;
  logic             nine_bit;
  logic [3:0]       data_bits;
  logic [4:0]       osr;
  logic [4:0]       half_bit;
  logic [8:0]       tx_data9;
  logic [3:0]       tx_total;
  logic [4:0]       tx_len;
  logic             pre_tick;
  logic [5:0]       pre_sum;
  logic [5:0]       pre_mod;
  logic             samp_tick;
  logic             rx_in;
  logic             addr_phase;
  logic [7:0]       rx_data;
  logic             rx_ninth;
  logic             rx_edge;

  // Read word for a register offset
  function automatic logic [31:0] read_word(input logic [7:0] a, input ubw_pkg::ubw_state_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (a)
      ubw_pkg::OFF_PORT_CTRL:
      begin
        w[ubw_pkg::PC_CHL_LO]     = s.chl_lo;
        w[ubw_pkg::PC_CHL_HI]     = s.chl_hi;
        w[ubw_pkg::PC_TX_NINTH]   = s.tx9;
        w[ubw_pkg::PC_TWO_STOP]   = s.two_stop;
        w[ubw_pkg::PC_SHORT_STOP] = s.short_stop;
        w[ubw_pkg::PC_SYNC]       = s.sync_mode;
        w[ubw_pkg::PC_TBE]        = s.tbe;
        w[ubw_pkg::PC_TX_BUSY]    = s.tx_active;
      end
      ubw_pkg::OFF_RX_CTRL:
      begin
        w[ubw_pkg::RC_RX_NINTH]  = s.rx9;
        w[ubw_pkg::RC_ADDR_WAIT] = s.addr_wait;
        w[ubw_pkg::RC_FRAME_ERR] = s.ferr;
        w[ubw_pkg::RC_OVERRUN]   = s.oerr;
        w[ubw_pkg::RC_RX_FULL]   = s.rx_full;
      end
      ubw_pkg::OFF_RX_HOLD:   w[7:0] = s.rx_buf;
      ubw_pkg::OFF_PRESCALE:  w[ubw_pkg::PSEL_W-1:0] = s.psel;
      ubw_pkg::OFF_DIVISOR:   w[ubw_pkg::DIV_W-1:0] = s.div;
      ubw_pkg::OFF_WAKE_EN:   w[7:0] = s.wake_enable_reg;
      ubw_pkg::OFF_WAKE_EDGE: w[7:0] = s.wake_edge_reg;
      default:                w = 32'h0000_0000;
    endcase
    return w;
  endfunction : read_word

  // Frame decode shared by transmitter and receiver
  always_comb
  begin
    loopback  = s_q.chl_lo & s_q.chl_hi;
    nine_bit  = s_q.chl_hi;
    data_bits = nine_bit ? 4'h9 : (s_q.chl_lo ? 4'h7 : 4'h8);
    osr       = s_q.sync_mode ? ubw_pkg::OSR_SYNC : ubw_pkg::OSR_ASYNC;
    half_bit  = s_q.sync_mode ? ubw_pkg::HALF_SYNC : ubw_pkg::HALF_ASYNC;
    if (nine_bit)
      tx_data9 = {s_q.tx9, s_q.tx_buf};
    else if (s_q.chl_lo)
      tx_data9 = {2'b11, s_q.tx_buf[6:0]};
    else
      tx_data9 = {1'b1, s_q.tx_buf};
    tx_total  = 4'h1 + data_bits + (s_q.two_stop ? 4'h2 : 4'h1);
    // Last stop bit may be shortened to seven eighths in async mode
    tx_len    = (s_q.tx_bits == 4'h1 && s_q.short_stop && !s_q.sync_mode) ? ubw_pkg::STOP_SHORT_LEN : osr;
  end

  // Half-step prescaler: adds two per clock, ticks once per (P+1)/2 clocks
  always_comb
  begin
    pre_sum  = s_q.pre_acc + 6'h02;
    pre_mod  = 6'(s_q.psel) + 6'h01;
    pre_tick = (s_q.psel != '0) && (pre_sum >= pre_mod);
    samp_tick = pre_tick && (s_q.div_cnt == '0);
  end

  // Receive source, received word alignment and wake edge
  always_comb
  begin
    rx_in    = loopback ? s_q.tx_sh[0] : s_q.rx_s2;
    rx_ninth = nine_bit & s_q.rx_sh[8];
    if (nine_bit)
      rx_data = s_q.rx_sh[7:0];
    else if (s_q.chl_lo)
      rx_data = {1'b0, s_q.rx_sh[8:2]};
    else
      rx_data = s_q.rx_sh[8:1];
    if (s_q.wake_edge_reg[ubw_pkg::WAKE_BIT])
      rx_edge = s_q.rx_prev & ~s_q.rx_s2;
    else
      rx_edge = ~s_q.rx_prev & s_q.rx_s2;
  end

  assign addr_phase = hsel && hready && htrans[1] && (hsize == 3'b010);

  // Next state of the whole port
  always_comb
  begin
    s_d = s_q;
    s_d.wake = 1'b0;
    s_d.rx_s1 = serial_in_pin;
    s_d.rx_s2 = s_q.rx_s1;
    s_d.rx_prev = s_q.rx_s2;

    // Bus address phase: capture write target, answer reads
    s_d.wr_pend = addr_phase && hwrite;
    if (addr_phase)
      s_d.wr_addr = haddr[7:0];
    if (addr_phase && !hwrite)
    begin
      s_d.hrdata = read_word(haddr[7:0], s_q);
      if (haddr[7:0] == ubw_pkg::OFF_RX_HOLD)
        s_d.rx_full = 1'b0;
    end

    // Bus data phase: register writes
    if (s_q.wr_pend)
    begin
      unique case (s_q.wr_addr)
        ubw_pkg::OFF_PORT_CTRL:
        begin
          s_d.chl_lo     = hwdata[ubw_pkg::PC_CHL_LO];
          s_d.chl_hi     = hwdata[ubw_pkg::PC_CHL_HI];
          s_d.tx9        = hwdata[ubw_pkg::PC_TX_NINTH];
          s_d.two_stop   = hwdata[ubw_pkg::PC_TWO_STOP];
          s_d.short_stop = hwdata[ubw_pkg::PC_SHORT_STOP];
          s_d.sync_mode  = hwdata[ubw_pkg::PC_SYNC];
        end
        ubw_pkg::OFF_RX_CTRL:
        begin
          s_d.addr_wait = hwdata[ubw_pkg::RC_ADDR_WAIT];
          s_d.ferr      = 1'b0;
          s_d.oerr      = 1'b0;
        end
        ubw_pkg::OFF_TX_HOLD:
        begin
          s_d.tx_buf = hwdata[7:0];
          s_d.tbe    = 1'b0;
        end
        ubw_pkg::OFF_PRESCALE:  s_d.psel  = hwdata[ubw_pkg::PSEL_W-1:0];
        ubw_pkg::OFF_DIVISOR:   s_d.div   = hwdata[ubw_pkg::DIV_W-1:0];
        ubw_pkg::OFF_WAKE_EN:   s_d.wake_enable_reg  = hwdata[7:0];
        ubw_pkg::OFF_WAKE_EDGE: s_d.wake_edge_reg = hwdata[7:0];
        default:                s_d.wake_enable_reg  = s_q.wake_enable_reg;
      endcase
    end

    // Divider chain: prescaler then divisor counter reloaded with N-1
    if (s_q.psel == '0)
    begin
      s_d.pre_acc = 6'h00;
      s_d.div_cnt = s_q.div;
    end
    else if (pre_tick)
    begin
      s_d.pre_acc = pre_sum - pre_mod;
      s_d.div_cnt = (s_q.div_cnt == '0) ? s_q.div : s_q.div_cnt - 1'b1;
    end
    else
      s_d.pre_acc = pre_sum;

    // Transmitter: load from holding buffer, shift out LSB first
    if (!s_q.tx_active && !s_q.tbe && (s_q.psel != '0))
    begin
      s_d.tx_sh     = {2'b11, tx_data9, 1'b0};
      s_d.tx_bits   = tx_total;
      s_d.tx_sub    = 5'h00;
      s_d.tx_active = 1'b1;
      s_d.tbe       = !(s_q.wr_pend && (s_q.wr_addr == ubw_pkg::OFF_TX_HOLD));
    end
    else if (s_q.tx_active && samp_tick)
    begin
      if (s_q.tx_sub == tx_len - 5'h01)
      begin
        s_d.tx_sub = 5'h00;
        s_d.tx_sh  = {1'b1, s_q.tx_sh[11:1]};
        if (s_q.tx_bits == 4'h1)
        begin
          s_d.tx_active = 1'b0;
          s_d.tx_sh     = '1;
        end
        else
          s_d.tx_bits = s_q.tx_bits - 4'h1;
      end
      else
        s_d.tx_sub = s_q.tx_sub + 5'h01;
    end

    // Receiver: verify start at mid-bit, then sample each bit once at mid-bit
    if (samp_tick)
    begin
      unique case (s_q.rx_st)
        ubw_pkg::RX_IDLE:
        begin
          if (!rx_in)
          begin
            s_d.rx_st  = ubw_pkg::RX_START;
            s_d.rx_sub = 5'h00;
          end
        end
        ubw_pkg::RX_START:
        begin
          if (s_q.rx_sub == half_bit - 5'h01)
          begin
            s_d.rx_sub  = 5'h00;
            s_d.rx_bits = data_bits;
            s_d.rx_st   = rx_in ? ubw_pkg::RX_IDLE : ubw_pkg::RX_DATA;
          end
          else
            s_d.rx_sub = s_q.rx_sub + 5'h01;
        end
        ubw_pkg::RX_DATA:
        begin
          if (s_q.rx_sub == osr - 5'h01)
          begin
            s_d.rx_sub  = 5'h00;
            s_d.rx_sh   = {rx_in, s_q.rx_sh[8:1]};
            s_d.rx_bits = s_q.rx_bits - 4'h1;
            if (s_q.rx_bits == 4'h1)
              s_d.rx_st = ubw_pkg::RX_STOP;
          end
          else
            s_d.rx_sub = s_q.rx_sub + 5'h01;
        end
        ubw_pkg::RX_STOP:
        begin
          if (s_q.rx_sub == osr - 5'h01)
          begin
            s_d.rx_st  = ubw_pkg::RX_IDLE;
            s_d.rx_sub = 5'h00;
            // Data characters are dropped while waiting for an address
            if (!(s_q.addr_wait && !rx_ninth))
            begin
              if (s_d.rx_full)
                s_d.oerr = 1'b1;
              s_d.rx_buf  = rx_data;
              s_d.rx9     = rx_ninth;
              s_d.rx_full = 1'b1;
              s_d.ferr    = s_d.ferr | ~rx_in;
              if (rx_ninth)
                s_d.addr_wait = 1'b0;
            end
          end
          else
            s_d.rx_sub = s_q.rx_sub + 5'h01;
        end
      endcase
    end

    // Low-power entry: reinitialise read-only state, keep buffers
    if (halt_enter || idle_enter)
    begin
      s_d.lp        = 1'b1;
      s_d.lp_halt   = halt_enter;
      s_d.tbe       = 1'b1;
      s_d.tx_active = 1'b0;
      s_d.rx_full   = 1'b0;
      s_d.rx9       = 1'b0;
      s_d.ferr      = 1'b0;
      s_d.oerr      = 1'b0;
      s_d.rx_st     = ubw_pkg::RX_IDLE;
      s_d.tx_sh     = '1;
      s_d.tx_buf    = s_q.tx_buf;
    end
    else if (s_q.lp && s_q.wake_enable_reg[ubw_pkg::WAKE_BIT] && rx_edge)
    begin
      // Edge on the receive pin chosen by the wake edge bit (falling, a start bit, when set; else rising) ends low-power
      s_d.lp   = 1'b0;
      s_d.wake = 1'b1;
      if (s_q.lp_halt && xtal_osc)
      begin
        s_d.exec_hold = 1'b1;
        s_d.hold_cnt  = ubw_pkg::HOLD_LOAD;
      end
    end

    // Oscillator settling hold-off after halt exit
    if (s_q.exec_hold)
    begin
      if (s_q.hold_cnt == 9'h000)
        s_d.exec_hold = 1'b0;
      else
        s_d.hold_cnt = s_q.hold_cnt - 9'h001;
    end
  end

  // State register with asynchronous reset to constants
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_q         <= '0;
      s_q.tbe     <= 1'b1;
      s_q.tx_sh   <= '1;
      s_q.rx_s1   <= 1'b1;
      s_q.rx_s2   <= 1'b1;
      s_q.rx_prev <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  // Outputs come straight from state, except hreadyout and hresp which are constants
  assign hrdata         = s_q.hrdata;
  assign hreadyout      = 1'b1;
  assign hresp          = 1'b0;
  assign serial_out_pin = s_q.tx_sh[0];
  assign wake_out       = s_q.wake;
  assign exec_hold      = s_q.exec_hold;

endmodule : ubw_usart

// >>> ubw_usart_props.sv
// Checker of the serial port's pin behaviour, bound to the serial port module
`timescale 1ns/1ps
module ubw_usart_props (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        serial_in_pin,
  input wire logic        serial_out_pin,
  input wire logic        halt_enter,
  input wire logic        idle_enter,
  input wire logic        xtal_osc,
  input wire logic        wake_out,
  input wire logic        exec_hold
);
  logic [8:0] hold_cnt_q;
  logic       ps_wr_q, ps_zero_q, halted_q;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // Hold length, prescale-zero shadow and kind of the last low-power entry
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hold_cnt_q <= 9'h000;
      ps_wr_q    <= 1'b0;
      ps_zero_q  <= 1'b1;
      halted_q   <= 1'b0;
    end
    else
    begin
      hold_cnt_q <= exec_hold ? hold_cnt_q + 9'h001 : 9'h000;
      ps_wr_q    <= hsel && hready && htrans[1] && hwrite && hsize == 3'b010
                    && haddr[7:0] == ubw_pkg::OFF_PRESCALE;
      if (ps_wr_q)
        ps_zero_q <= hwdata[4:0] == 5'h00;
      if (halt_enter)
        halted_q <= 1'b1;
      else if (idle_enter)
        halted_q <= 1'b0;
    end
  end
  // Steps of low-power entry and of a start edge on the pin
  sequence s_entry;
    halt_enter || idle_enter;
  endsequence
  sequence s_start_low;
    !$past(serial_in_pin, 2) || !$past(serial_in_pin, 3) || !$past(serial_in_pin, 4);
  endsequence
  property p_entry_line; s_entry |=> serial_out_pin; endproperty
  a_entry_line: assert property (p_entry_line) else $error("line not idle after entry");
  property p_wake_pulse; wake_out |=> !wake_out; endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake pulse too long");
  property p_wake_src; $rose(wake_out) |-> s_start_low; endproperty
  a_wake_src: assert property (p_wake_src) else $error("wake without start edge");
  property p_hold_src; $rose(exec_hold) |-> xtal_osc && (wake_out || $past(wake_out)); endproperty
  a_hold_src: assert property (p_hold_src) else $error("hold without crystal wake");
  property p_hold_halt; $rose(exec_hold) |-> halted_q; endproperty
  a_hold_halt: assert property (p_hold_halt) else $error("hold after idle");
  property p_hold_len; $fell(exec_hold) |-> hold_cnt_q == 9'h100; endproperty
  a_hold_len: assert property (p_hold_len) else $error("hold length wrong");
  property p_hold_max; hold_cnt_q <= 9'h100; endproperty
  a_hold_max: assert property (p_hold_max) else $error("hold too long");
  property p_clock_stop;
    ps_zero_q && !$past(halt_enter) && !$past(idle_enter) |-> $stable(serial_out_pin);
  endproperty
  a_clock_stop: assert property (p_clock_stop) else $error("line moved with clock off");
endmodule : ubw_usart_props
bind ubw_usart ubw_usart_props i_props (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
  .serial_in_pin, .serial_out_pin, .halt_enter, .idle_enter, .xtal_osc, .wake_out, .exec_hold);

// >>> ubw_peer.sv
// Remote serial station: sends and samples nine-bit frames
`timescale 1ns/1ps
module ubw_peer (
  input  wire logic hclk,
  input  wire logic line_in,
  output logic      line_out
);
  initial line_out = 1'b1;
  // Drives one bit for bc clocks
  task automatic hold_bit(input logic b, input int bc);
    line_out <= b;
    repeat (bc) @(posedge hclk);
  endtask : hold_bit
  // Start, nine data bits LSB first, stop, then idle high
  task automatic send(input logic [8:0] d, input int bc, input logic stop_v);
    hold_bit(1'b0, bc);
    for (int i = 0; i < 9; i++)
      hold_bit(d[i], bc);
    hold_bit(stop_v, bc);
    hold_bit(1'b1, bc);
  endtask : send
  // Finds the start edge, samples nine data bits and stop at mid-bit
  task automatic recv(input int bc, output logic [9:0] d);
    for (int w = 0; w < 5000 && line_in !== 1'b0; w++)
      @(posedge hclk);
    repeat (bc / 2) @(posedge hclk);
    for (int i = 0; i < 10; i++)
    begin
      repeat (bc) @(posedge hclk);
      d[i] = line_in;
    end
  endtask : recv
endmodule : ubw_peer

// >>> ubw_usart_tb_top.sv
// Testbench of the serial port: rates, reset, address filter, loopback, low power
`timescale 1ns/1ps
module ubw_usart_tb_top;
  typedef struct packed {
    logic [4:0]  psel;
    logic [10:0] div;
    logic [7:0]  ctrl;
    logic [7:0]  bc;
    logic [8:0]  chr;
  } ubw_row_t;
  // Rate settings beside the bit length and frame they should give
  localparam ubw_row_t ROWS [5] = '{
    '{5'h01, 11'h000, 8'h06, 8'h10, 9'h1A5},
    '{5'h01, 11'h002, 8'h02, 8'h30, 9'h05A},
    '{5'h03, 11'h001, 8'h06, 8'h40, 9'h1C3},
    '{5'h01, 11'h002, 8'h22, 8'h06, 9'h0F0},
    '{5'h01, 11'h00B, 8'h02, 8'hC0, 9'h0A5}};
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        halt_enter = 1'b0, idle_enter = 1'b0, xtal_osc = 1'b0;
  logic        hreadyout, hresp, serial_in_pin, serial_out_pin, wake_out, exec_hold;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'b010;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, v;
  logic [9:0]  frame;
  int          fail_count = 0, checked = 0, cyc = 0, k;
  ubw_usart i_dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .serial_in_pin, .serial_out_pin,
    .halt_enter, .idle_enter, .xtal_osc, .wake_out, .exec_hold);
  ubw_peer i_peer (.hclk, .line_in(serial_out_pin), .line_out(serial_in_pin));
  // 25 MHz clock
  always #20 hclk = ~hclk;
  // Run limit
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      fail_count++;
      report_and_stop();
    end
  end
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask : cmp
  // One AHB-Lite single word transfer
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d, v);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0, v);
    cmp($sformatf("register %h", a), e, v);
  endtask : rd
  task automatic reset_dut();
    hresetn <= 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask : reset_dut
  task automatic done(input string n);
    $display("test %s finished", n);
  endtask : done
  // Waits for the wake pulse, then counts the settling hold
  task automatic wake_check(input logic [31:0] hold_exp);
    for (k = 0; k < 2000 && wake_out !== 1'b1; k++) @(posedge hclk);
    cmp("wake_out", 32'h1, {31'h0, wake_out});
    for (k = 0; k < 3 && exec_hold !== 1'b1; k++) @(posedge hclk);
    for (k = 0; k < 600 && exec_hold === 1'b1; k++) @(posedge hclk);
    cmp("exec_hold cycles", hold_exp, 32'(k));
  endtask : wake_check
  task automatic report_and_stop();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop
  initial
  begin
    reset_dut();
    // Frame timing and content for each rate setting
    foreach (ROWS[i])
    begin
      wr(ubw_pkg::OFF_PRESCALE, {27'h0, ROWS[i].psel});
      wr(ubw_pkg::OFF_DIVISOR, {21'h0, ROWS[i].div});
      wr(ubw_pkg::OFF_PORT_CTRL, {24'h0, ROWS[i].ctrl});
      wr(ubw_pkg::OFF_TX_HOLD, {24'h0, ROWS[i].chr[7:0]});
      i_peer.recv(ROWS[i].bc, frame);
      cmp("tx frame", {23'h1, ROWS[i].chr}, {22'h0, frame});
    end
    done("rates");
    // Reset values, unmapped place, clock held off then released
    reset_dut();
    rd(ubw_pkg::OFF_PORT_CTRL, 32'h40);
    rd(ubw_pkg::OFF_PRESCALE, 32'h0);
    wr(ubw_pkg::OFF_PORT_CTRL, 32'h2);
    wr(ubw_pkg::OFF_TX_HOLD, 32'h55);
    wr(8'h20, 32'hFFFFFFFF);
    rd(8'h20, 32'h0);
    wr(ubw_pkg::OFF_DIVISOR, 32'hFFFFFFFF);
    rd(ubw_pkg::OFF_DIVISOR, 32'h7FF);
    cmp("line with clock off", 32'h1, {31'h0, serial_out_pin});
    wr(ubw_pkg::OFF_DIVISOR, 32'h0);
    wr(ubw_pkg::OFF_PRESCALE, 32'h1);
    i_peer.recv(16, frame);
    cmp("held frame", 32'h255, {22'h0, frame});
    done("reset and clock stop");
    // Address filter, then a framing error cleared by a write
    wr(ubw_pkg::OFF_RX_CTRL, 32'h2);
    i_peer.send(9'h055, 16, 1'b1);
    rd(ubw_pkg::OFF_RX_CTRL, 32'h2);
    i_peer.send(9'h1C3, 16, 1'b1);
    rd(ubw_pkg::OFF_RX_CTRL, 32'h11);
    rd(ubw_pkg::OFF_RX_HOLD, 32'hC3);
    i_peer.send(9'h042, 16, 1'b1);
    rd(ubw_pkg::OFF_RX_CTRL, 32'h10);
    rd(ubw_pkg::OFF_RX_HOLD, 32'h42);
    i_peer.send(9'h033, 16, 1'b0);
    rd(ubw_pkg::OFF_RX_CTRL, 32'h14);
    wr(ubw_pkg::OFF_RX_CTRL, 32'h0);
    rd(ubw_pkg::OFF_RX_CTRL, 32'h10);
    rd(ubw_pkg::OFF_RX_HOLD, 32'h33);
    done("address filter");
    // Loopback: frame comes back through the receiver with ninth bit
    wr(ubw_pkg::OFF_PORT_CTRL, 32'h7);
    wr(ubw_pkg::OFF_TX_HOLD, 32'h5A);
    v = 32'h0;
    for (int j = 0; j < 200 && v[4] !== 1'b1; j++) bus(ubw_pkg::OFF_RX_CTRL, 1'b0, 32'h0, v);
    cmp("loop status", 32'h11, v);
    done("loopback");
    // Halt entry in mid-frame, then wake by start edge
    wr(ubw_pkg::OFF_RX_CTRL, 32'h2);
    wr(ubw_pkg::OFF_TX_HOLD, 32'h3C);
    repeat (40) @(posedge hclk);
    halt_enter <= 1'b1;
    @(posedge hclk);
    halt_enter <= 1'b0;
    @(posedge hclk);
    cmp("line at entry", 32'h1, {31'h0, serial_out_pin});
    rd(ubw_pkg::OFF_PORT_CTRL, 32'h47);
    rd(ubw_pkg::OFF_RX_CTRL, 32'h2);
    rd(ubw_pkg::OFF_RX_HOLD, 32'h5A);
    wr(ubw_pkg::OFF_PORT_CTRL, 32'h2);
    wr(ubw_pkg::OFF_WAKE_EDGE, 32'h8);
    wr(ubw_pkg::OFF_WAKE_EN, 32'h8);
    xtal_osc <= 1'b1;
    fork
      i_peer.send(9'h0AA, 16, 1'b1);
      wake_check(32'h100);
    join
    idle_enter <= 1'b1;
    @(posedge hclk);
    idle_enter <= 1'b0;
    fork
      i_peer.send(9'h0AA, 16, 1'b1);
      wake_check(32'h0);
    join
    done("low power");
    report_and_stop();
  end
endmodule : ubw_usart_tb_top
